//--- core/mtl_counter_limit.sv
// Multiturn revolution counter with wrap limit, limit write utility,
// origin offset and serial alarm report. Assumes same-clock step, key and
// command pulses; only motorPowerOn arrives asynchronously.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "mtl_regs.svh"

module mtl_counter_limit #(
  parameter int unsigned DONE_CYC = `MTL_DONE_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // AXI4-Lite slave
  input  wire logic [4:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [4:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Encoder side
  input  wire logic               motorPowerOn,
  input  wire logic               revFwdStep,
  input  wire logic               revRevStep,
  input  wire logic [15:0]        encStoredLimit,
  input  wire logic [31:0]        encPosition,
  output logic                    encLimitWrite,
  output logic [15:0]             encLimitData,
  // Host commands and panel keys
  input  wire logic               sensorOnCommand,
  input  wire logic               sensorOffCommand,
  input  wire logic               keyUtility,
  input  wire logic               keyExecute,
  input  wire logic               keyReturn,
  // Outputs
  output logic                    phaseAPulseOut,
  output logic                    servoFaultOutput,
  output logic [15:0]             revCount,
  output logic                    revCountValid,
  output logic [31:0]             machineCoordinatePosition,
  output logic                    limitMismatchAlarm,
  output mtl_pkg::mtl_disp_t      dispStatus
);
  import mtl_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  function automatic logic [6:0] hexChar(input logic [3:0] d);
    return (d < 4'hA) ? (7'h30 + {3'h0, d}) : (7'h37 + {3'h0, d});
  endfunction : hexChar

  function automatic logic [9:0] frameOf(input logic [2:0] idx, input logic [11:0] code);
    logic [6:0] ch;
    ch = (idx == 3'h0) ? 7'h45 : (idx == 3'h1) ? hexChar(code[11:8]) :
         (idx == 3'h2) ? hexChar(code[7:4]) : (idx == 3'h3) ? hexChar(code[3:0]) : 7'h0D;
    return {1'b1, ^ch, ch, 1'b0};
  endfunction : frameOf

  // ==========================================================
  // State
  logic [1:0]  pwrSync_reg;
  logic [4:0]  ctrl_reg;
  logic [15:0] limitParam_reg, activeLimit_reg, revCount_reg;
  logic [31:0] offsetParam_reg, alarmCode_reg, machinePos_reg;
  logic        awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
  logic [4:0]  awAddr_reg;
  logic [31:0] wData_reg, rdata_reg;
  logic [3:0]  wStrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        mismatch_reg, checked_reg, sensorOn_reg, offRefused_reg;
  logic        servoOk_reg, noOp_reg, encWr_reg;
  logic [15:0] encWrData_reg;
  mtl_util_t   util_reg;
  mtl_disp_t   disp_reg;
  logic [23:0] doneCnt_reg;
  logic        txBusy_reg, txLine_reg;
  logic [9:0]  txShift_reg;
  logic [3:0]  txBit_reg;
  logic [10:0] baudCnt_reg;
  logic [2:0]  charIdx_reg;
  logic [11:0] txCode_reg;

  // ==========================================================
  // Bus decode
  wire         doWrite   = awHeld_reg && wHeld_reg && !bvalid_reg;
  wire         selCtrl   = awAddr_reg == `MTL_ADDR_CTRL;
  wire         selLimit  = awAddr_reg == `MTL_ADDR_LIMIT;
  wire         selOffset = awAddr_reg == `MTL_ADDR_OFFSET;
  wire         selAlarm  = awAddr_reg == `MTL_ADDR_ALARM;
  wire         wrHit     = selCtrl || selLimit || selOffset || selAlarm;
  wire [31:0]  ctrlNew   = mergeBytes({27'h0, ctrl_reg}, wData_reg, wStrb_reg);
  wire [31:0]  limitNew  = mergeBytes({16'h0, limitParam_reg}, wData_reg, wStrb_reg);
  wire [31:0]  offNew    = mergeBytes(offsetParam_reg, wData_reg, wStrb_reg);
  wire signed [31:0] offS = offNew;
  wire [31:0]  offClamp  = (offS > `MTL_OFFSET_MAX) ? `MTL_OFFSET_MAX :
                           (offS < -`MTL_OFFSET_MAX) ? -`MTL_OFFSET_MAX : offNew;
  wire         memWrite  = doWrite && selCtrl && ctrlNew[`MTL_CTRL_MEMWR];
  wire         restart   = doWrite && selCtrl && ctrlNew[`MTL_CTRL_RESTART];
  wire [31:0]  status    = {revCount_reg, 8'h0, 2'h0, util_reg, offRefused_reg,
                            sensorOn_reg, txBusy_reg, mismatch_reg};
  wire [4:0]   ra        = s_axi_araddr;
  wire         rdHit     = ra == `MTL_ADDR_CTRL || ra == `MTL_ADDR_LIMIT ||
                           ra == `MTL_ADDR_OFFSET || ra == `MTL_ADDR_STATUS ||
                           ra == `MTL_ADDR_ALARM;
  wire [31:0]  rdMux     = (ra == `MTL_ADDR_CTRL) ? {27'h0, ctrl_reg} :
                           (ra == `MTL_ADDR_LIMIT) ? {16'h0, limitParam_reg} :
                           (ra == `MTL_ADDR_OFFSET) ? offsetParam_reg :
                           (ra == `MTL_ADDR_STATUS) ? status :
                           (ra == `MTL_ADDR_ALARM) ? alarmCode_reg : 32'h0;

  assign s_axi_awready = !awHeld_reg && !bvalid_reg;
  assign s_axi_wready  = !wHeld_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ==========================================================
  // Block decode
  wire absEnc     = ctrl_reg[`MTL_CTRL_ABS];
  wire singleTurn = ctrl_reg[`MTL_CTRL_SINGLE];
  wire wProt      = ctrl_reg[`MTL_CTRL_WPROT];
  wire offAccept  = sensorOffCommand && absEnc && !pwrSync_reg[1];
  wire sendStart  = offAccept && !txBusy_reg;
  wire fwdOnly    = revFwdStep && !revRevStep;
  wire revOnly    = revRevStep && !revFwdStep;
  wire execWrite  = util_reg == UTIL_ARMED && keyExecute;
  wire baudEnd    = baudCnt_reg == 11'(`MTL_BIT_CYC - 1);
  wire [31:0] offsetEff = sensorOn_reg ? offsetParam_reg : 32'h0;

  // ==========================================================
  // Bus slave
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      awAddr_reg <= 5'h00;
      wData_reg  <= 32'h0;
      wStrb_reg  <= 4'h0;
      bresp_reg  <= `MTL_RESP_OKAY;
      rdata_reg  <= 32'h0;
      rresp_reg  <= `MTL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wrHit ? `MTL_RESP_OKAY : `MTL_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rdMux;
        rresp_reg  <= rdHit ? `MTL_RESP_OKAY : `MTL_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Parameters; limit change waits for restart so counting never jumps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg        <= 5'h00;
      limitParam_reg  <= `MTL_LIMIT_DEFAULT;
      activeLimit_reg <= `MTL_LIMIT_DEFAULT;
      offsetParam_reg <= 32'h0;
      alarmCode_reg   <= 32'h0;
    end else begin
      if (doWrite && selCtrl) ctrl_reg <= {2'b00, ctrlNew[2:0]};
      if (doWrite && selLimit) limitParam_reg <= limitNew[15:0];
      if (doWrite && selOffset) offsetParam_reg <= offClamp;
      if (doWrite && selAlarm) alarmCode_reg <= mergeBytes(alarmCode_reg, wData_reg, wStrb_reg);
      if (restart) activeLimit_reg <= limitParam_reg;
    end
  end

  // ==========================================================
  // Revolution counter and positions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwrSync_reg    <= 2'b00;
      revCount_reg   <= 16'h0;
      mismatch_reg   <= 1'b0;
      checked_reg    <= 1'b0;
      sensorOn_reg   <= 1'b0;
      offRefused_reg <= 1'b0;
      machinePos_reg <= 32'h0;
      servoOk_reg    <= 1'b0;
    end else begin
      pwrSync_reg  <= {pwrSync_reg[0], motorPowerOn};
      mismatch_reg <= absEnc && (activeLimit_reg != encStoredLimit);
      checked_reg  <= 1'b1;
      if (singleTurn) begin
        revCount_reg <= 16'h0;
      end else if (fwdOnly) begin
        revCount_reg <= (revCount_reg >= activeLimit_reg) ? 16'h0 : revCount_reg + 16'h1;
      end else if (revOnly) begin
        revCount_reg <= (revCount_reg == 16'h0) ? activeLimit_reg : revCount_reg - 16'h1;
      end
      if (sensorOnCommand) sensorOn_reg <= 1'b1;
      else if (offAccept) sensorOn_reg <= 1'b0;
      if (sensorOffCommand) offRefused_reg <= !offAccept;
      machinePos_reg <= encPosition - offsetEff;
      servoOk_reg    <= !mismatch_reg && alarmCode_reg == 32'h0;
    end
  end

  assign revCount                  = revCount_reg;
  assign revCountValid             = checked_reg;
  assign machineCoordinatePosition = machinePos_reg;
  assign limitMismatchAlarm        = mismatch_reg;
  assign servoFaultOutput          = servoOk_reg;

  // ==========================================================
  // Limit write utility
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      util_reg      <= UTIL_IDLE;
      noOp_reg      <= 1'b0;
      doneCnt_reg   <= 24'h0;
      encWr_reg     <= 1'b0;
      encWrData_reg <= `MTL_LIMIT_DEFAULT;
      disp_reg      <= DISP_NORMAL;
    end else begin
      encWr_reg <= execWrite || memWrite;
      if (execWrite || memWrite) encWrData_reg <= limitParam_reg;
      case (util_reg)
        UTIL_IDLE: begin
          if (keyUtility) begin
            noOp_reg <= wProt;
            if (!wProt) util_reg <= UTIL_ARMED;
          end
        end
        UTIL_ARMED: begin
          if (keyExecute) begin
            util_reg    <= UTIL_DONE;
            doneCnt_reg <= 24'h0;
          end else if (keyReturn) begin
            util_reg <= UTIL_IDLE;
          end
        end
        UTIL_DONE: begin
          doneCnt_reg <= doneCnt_reg + 24'h1;
          if (doneCnt_reg == 24'(DONE_CYC - 1)) util_reg <= UTIL_IDLE;
        end
        default: util_reg <= UTIL_IDLE;
      endcase
      disp_reg <= (util_reg == UTIL_DONE) ? DISP_DONE : noOp_reg ? DISP_NOOP :
                  mismatch_reg ? DISP_ALARM : DISP_NORMAL;
    end
  end

  assign encLimitWrite = encWr_reg;
  assign encLimitData  = encWrData_reg;
  assign dispStatus    = disp_reg;

  // ==========================================================
  // Serial alarm report: 'E', three hex digits, CR
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txBusy_reg  <= 1'b0;
      txLine_reg  <= 1'b1;
      txShift_reg <= 10'h3FF;
      txBit_reg   <= 4'h0;
      baudCnt_reg <= 11'h0;
      charIdx_reg <= 3'h0;
      txCode_reg  <= 12'h0;
    end else if (sendStart) begin
      txBusy_reg  <= 1'b1;
      txCode_reg  <= mismatch_reg ? `MTL_MISMATCH_CODE : alarmCode_reg[11:0];
      txShift_reg <= frameOf(3'h0, mismatch_reg ? `MTL_MISMATCH_CODE : alarmCode_reg[11:0]);
      txLine_reg  <= 1'b0;
      txBit_reg   <= 4'h0;
      baudCnt_reg <= 11'h0;
      charIdx_reg <= 3'h0;
    end else if (txBusy_reg) begin
      baudCnt_reg <= baudEnd ? 11'h0 : baudCnt_reg + 11'h1;
      if (baudEnd && txBit_reg == `MTL_LAST_BIT) begin
        if (charIdx_reg == `MTL_LAST_CHAR) begin
          txBusy_reg <= 1'b0;
          txLine_reg <= 1'b1;
        end else begin
          charIdx_reg <= charIdx_reg + 3'h1;
          txShift_reg <= frameOf(charIdx_reg + 3'h1, txCode_reg);
          txLine_reg  <= 1'b0;
          txBit_reg   <= 4'h0;
        end
      end else if (baudEnd) begin
        txShift_reg <= {1'b1, txShift_reg[9:1]};
        txLine_reg  <= txShift_reg[1];
        txBit_reg   <= txBit_reg + 4'h1;
      end
    end
  end

  assign phaseAPulseOut = txLine_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wrap_forward: assert property (fwdOnly && !singleTurn && revCount_reg == activeLimit_reg
    |=> revCount_reg == 16'h0) else $error("forward wrap missed");
  a_wrap_reverse: assert property (revOnly && !singleTurn && revCount_reg == 16'h0
    |=> revCount_reg == $past(activeLimit_reg)) else $error("reverse wrap missed");
  a_single_turn: assert property (singleTurn |=> revCount_reg == 16'h0)
    else $error("single-turn count not zero");
  a_mismatch_flag: assert property (absEnc && activeLimit_reg != encStoredLimit
    |=> mismatch_reg ##1 disp_reg != DISP_NORMAL) else $error("mismatch not raised");
  a_refuse_off: assert property (sensorOffCommand && pwrSync_reg[1] && !txBusy_reg
    |=> !txBusy_reg && offRefused_reg) else $error("sensor-off taken under power");
  a_return_nowrite: assert property (util_reg == UTIL_ARMED && keyReturn && !keyExecute
    && !memWrite |=> !encWr_reg ##0 util_reg == UTIL_IDLE) else $error("return wrote");
  a_noop_entry: assert property (util_reg == UTIL_IDLE && keyUtility && wProt
    |=> util_reg == UTIL_IDLE ##1 disp_reg == DISP_NOOP) else $error("entry not refused");
  a_done_shown: assert property (execWrite |=> encWr_reg ##1 (disp_reg == DISP_DONE)[*8])
    else $error("done not shown");
  a_start_bit: assert property (sendStart |=> txBusy_reg && !phaseAPulseOut)
    else $error("no start bit");
  a_fault_out: assert property (mismatch_reg |=> !servoFaultOutput)
    else $error("fault output closed on error");
  a_offset_apply: assert property (sensorOn_reg
    |=> machinePos_reg == $past(encPosition) - $past(offsetParam_reg))
    else $error("offset not applied");

  c_report_sent: cover property (txBusy_reg && baudEnd && txBit_reg == `MTL_LAST_BIT
    && charIdx_reg == `MTL_LAST_CHAR ##1 !txBusy_reg);
  c_limit_written: cover property (util_reg == UTIL_ARMED ##1 execWrite);
  c_reverse_wrap: cover property (revOnly && revCount_reg == 16'h0 && !singleTurn);
endmodule : mtl_counter_limit

//--- core/mtl_regs.svh
// Register map, field positions, reset values and timing counts.
// Assumes a 10 MHz core clock and byte addresses on a 32-bit AXI4-Lite bus.
`ifndef MTL_REGS_SVH
`define MTL_REGS_SVH
// ==========================================================
// Register offsets
`define MTL_ADDR_CTRL     5'h00
`define MTL_ADDR_LIMIT    5'h04
`define MTL_ADDR_OFFSET   5'h08
`define MTL_ADDR_STATUS   5'h0C
`define MTL_ADDR_ALARM    5'h10
// ==========================================================
// Control bits
`define MTL_CTRL_ABS      0
`define MTL_CTRL_SINGLE   1
`define MTL_CTRL_WPROT    2
`define MTL_CTRL_MEMWR    3
`define MTL_CTRL_RESTART  4
// ==========================================================
// Reset values and limits
`define MTL_LIMIT_DEFAULT 16'hFFFF
`define MTL_OFFSET_MAX    32'sh3FFFFFFF
`define MTL_MISMATCH_CODE 12'hCC0
`define MTL_RESP_OKAY     2'b00
`define MTL_RESP_SLVERR   2'b10
// ==========================================================
// Timing
`define MTL_CLK_HZ        10000000
`define MTL_BAUD          9600
`define MTL_BIT_CYC       (`MTL_CLK_HZ / `MTL_BAUD)
`define MTL_DONE_MS       1000
`define MTL_DONE_CYC      (`MTL_CLK_HZ / 1000 * `MTL_DONE_MS)
`define MTL_LAST_CHAR     3'h4
`define MTL_LAST_BIT      4'h9
`endif

//--- core/mtl_pkg.sv
// Types shared by the multiturn counter block.
// Assumes mtl_regs.svh carries all numeric constants.
package mtl_pkg;
  // ==========================================================
  // Limit write utility states
  typedef enum logic [1:0] {
    UTIL_IDLE  = 2'b00,
    UTIL_ARMED = 2'b01,
    UTIL_DONE  = 2'b11
  } mtl_util_t;
  // ==========================================================
  // Status display
  typedef enum logic [1:0] {
    DISP_NORMAL = 2'b00,
    DISP_ALARM  = 2'b01,
    DISP_NOOP   = 2'b10,
    DISP_DONE   = 2'b11
  } mtl_disp_t;
endpackage : mtl_pkg

//--- tb/mtl_host_model.sv
// Host side model: receives the alarm text sent on the phase-A serial line.
// Assumes a 10 MHz clock and an idle-high line from the block.
`timescale 1ns/1ns
module mtl_host_model #(
  parameter int BIT_CYC = 1041
) (
  // Clock and serial line
  input  wire logic        clk,
  input  wire logic        serialIn,
  // Received characters, newest in the low byte
  output logic [39:0]      rxChars,
  output logic [3:0]       rxCount,
  output logic             rxFrameErr
);
  // ==========================================================
  // Receiver
  initial begin
    logic [7:0] bits;
    rxChars    = '0;
    rxCount    = '0;
    rxFrameErr = 1'b0;
    forever begin
      @(posedge clk iff serialIn === 1'b0);
      // Sample mid-bit, so a slightly long or short bit still reads right
      repeat (BIT_CYC / 2) @(posedge clk);
      if (serialIn !== 1'b0) rxFrameErr = 1'b1;
      // Seven data bits then parity; the stop bit is sampled on its own below
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        bits[i] = serialIn;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (serialIn !== 1'b1 || ^bits !== 1'b0) rxFrameErr = 1'b1;
      rxChars = {rxChars[31:0], 1'b0, bits[6:0]};
      rxCount = rxCount + 4'h1;
    end
  end
endmodule : mtl_host_model

//--- tb/test_multiturn_counter_limit.sv
// Self-checking bench for the multiturn counter block.
// Assumes mtl_host_model beside it; the done period is shortened to 20.
`timescale 1ns/1ns
`include "mtl_regs.svh"
module test_multiturn_counter_limit;
  import mtl_pkg::*;
  localparam int DONE = 20;
  // ==========================================================
  // Signals
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [4:0]  awAddr = '0, arAddr = '0;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic        arValid = 1'b0, rReady = 1'b0;
  logic [31:0] wData = '0, encPos = '0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData, machPos;
  logic        powerOn = 1'b1, fwd = 1'b0, rev = 1'b0, sOn = 1'b0, sOff = 1'b0;
  logic        kUtil = 1'b0, kExec = 1'b0, kRet = 1'b0;
  logic [15:0] encLim = 16'hFFFF, limData, revCount;
  logic        limWr, phaseA, servoOk, cntValid, alarm, rxErr;
  mtl_disp_t   disp;
  logic [39:0] rxChars;
  logic [3:0]  rxCount;
  int          errors = 0, numChecks = 0, cycles = 0;

  mtl_counter_limit #(.DONE_CYC(DONE)) mtl_counter_limit_inst (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .motorPowerOn(powerOn), .revFwdStep(fwd), .revRevStep(rev),
    .encStoredLimit(encLim), .encPosition(encPos),
    .encLimitWrite(limWr), .encLimitData(limData),
    .sensorOnCommand(sOn), .sensorOffCommand(sOff),
    .keyUtility(kUtil), .keyExecute(kExec), .keyReturn(kRet),
    .phaseAPulseOut(phaseA), .servoFaultOutput(servoOk), .revCount(revCount),
    .revCountValid(cntValid), .machineCoordinatePosition(machPos),
    .limitMismatchAlarm(alarm), .dispStatus(disp));

  mtl_host_model mtl_host_model_inst (
    .clk(clk), .serialIn(phaseA), .rxChars(rxChars), .rxCount(rxCount),
    .rxFrameErr(rxErr));

  // ==========================================================
  // Clock, timeout and encoder limit store
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      summarize();
    end
  end
  // The encoder keeps what the block writes to it
  always @(posedge clk) if (limWr) encLim <= limData;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic axiWr(input logic [4:0] a, input logic [31:0] d);
    logic awDone, wDone;
    @(posedge clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    awDone = 1'b0;
    wDone  = 1'b0;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (awValid && awReady) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wValid && wReady) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    while (bValid !== 1'b1) @(posedge clk);
    chk(32'(bResp), 32'(`MTL_RESP_OKAY));
    bReady <= 1'b0;
  endtask : axiWr

  task automatic axiRd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1) @(posedge clk);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask : axiRd

  // One-cycle pulse: 0 utility, 1 execute, 2 return, 3 sensor-on, 4 sensor-off
  task automatic pulse(input int k);
    @(posedge clk);
    {kUtil, kExec, kRet, sOn, sOff} <= 5'h10 >> k;
    @(posedge clk);
    {kUtil, kExec, kRet, sOn, sOff} <= 5'h00;
  endtask : pulse

  task automatic step(input logic f);
    @(posedge clk);
    fwd <= f;
    rev <= !f;
    @(posedge clk);
    fwd <= 1'b0;
    rev <= 1'b0;
    settle(1);
  endtask : step

  // ==========================================================
  // Scenarios
  task automatic tReset();
    logic [31:0] d;
    logic [1:0]  r;
    settle(2);
    chk(32'(revCount), 32'h0);
    chk(32'(servoOk), 32'h1);
    chk(32'(cntValid), 32'h1);
    axiRd(`MTL_ADDR_LIMIT, d, r);
    chk(d, 32'h0000FFFF);
    axiRd(5'h14, d, r);
    chk(32'(r), 32'(`MTL_RESP_SLVERR));
    $display("reset test done");
  endtask : tReset

  task automatic tWrap();
    axiWr(`MTL_ADDR_LIMIT, 32'h2);
    axiWr(`MTL_ADDR_CTRL, 32'h11);
    settle(2);
    chk(32'(alarm), 32'h1);
    chk(32'(servoOk), 32'h0);
    chk(32'(disp), 32'(DISP_ALARM));
    axiWr(`MTL_ADDR_CTRL, 32'h09);
    settle(3);
    chk(32'(encLim), 32'h2);
    chk(32'(alarm), 32'h0);
    step(1'b0);
    chk(32'(revCount), 32'h2);
    step(1'b1);
    chk(32'(revCount), 32'h0);
    $display("wrap test done");
  endtask : tWrap

  task automatic tUtility();
    axiWr(`MTL_ADDR_LIMIT, 32'h5);
    axiWr(`MTL_ADDR_CTRL, 32'h15);
    pulse(0);
    settle(3);
    chk(32'(disp), 32'(DISP_NOOP));
    axiWr(`MTL_ADDR_CTRL, 32'h01);
    pulse(0);
    pulse(2);
    settle(3);
    chk(32'(encLim), 32'h2);
    pulse(0);
    pulse(1);
    settle(3);
    chk(32'(encLim), 32'h5);
    settle(DONE - 8);
    chk(32'(disp), 32'(DISP_DONE));
    settle(10);
    chk(32'(disp), 32'(DISP_NORMAL));
    step(1'b1);
    chk(32'(revCount), 32'h1);
    axiWr(`MTL_ADDR_CTRL, 32'h03);
    step(1'b1);
    chk(32'(revCount), 32'h0);
    $display("utility test done");
  endtask : tUtility

  task automatic tOffset();
    logic [31:0] d;
    logic [1:0]  r;
    axiWr(`MTL_ADDR_OFFSET, 32'd100);
    @(posedge clk);
    encPos <= 32'd1000;
    settle(3);
    chk(machPos, 32'd1000);
    pulse(3);
    settle(3);
    chk(machPos, 32'd900);
    axiWr(`MTL_ADDR_OFFSET, 32'h7FFFFFFF);
    axiRd(`MTL_ADDR_OFFSET, d, r);
    chk(d, 32'h3FFFFFFF);
    $display("offset test done");
  endtask : tOffset

  task automatic tSerial();
    logic [31:0] d;
    logic [1:0]  r;
    axiWr(`MTL_ADDR_LIMIT, 32'h7);
    axiWr(`MTL_ADDR_CTRL, 32'h11);
    // Host breaks its side on purpose: sensor-off with power still on
    pulse(4);
    settle(3);
    chk(32'(phaseA), 32'h1);
    axiRd(`MTL_ADDR_STATUS, d, r);
    chk(32'(d[3]), 32'h1);
    @(posedge clk);
    powerOn <= 1'b0;
    settle(4);
    pulse(4);
    while (rxCount !== 4'h5) @(posedge clk);
    chk(rxChars[39:8], 32'h45434330);
    chk(32'(rxChars[7:0]), 32'h0D);
    chk(32'(rxErr), 32'h0);
    $display("serial test done");
  endtask : tSerial

  // ==========================================================
  // Sequence and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    tReset();
    tWrap();
    tUtility();
    tOffset();
    tSerial();
    summarize();
  end
endmodule : test_multiturn_counter_limit
